// ### src/ffs_sequencer.sv
// Four-phase instruction fetch/execute sequencer with 8-bit ALU
`timescale 1ns/100ps

// Functional notes
// [RL1] Four non-overlapping phase clocks from system clock
// [RL2] System clock chosen from four oscillator sources
// [RL3] T1 start: advance counter, fetch new word
// [RL4] T2 to T4 decode and execute
// [RL5] One QUARTER_PHASE_CLOCKS pass is one instruction cycle
// [RL6] Fetch overlaps execution of previous instruction
// [RL7] Standard one cycle, extended two cycles
// [RL8] Counter-changing instructions cost one extra cycle
// [RL9] Branch: obtain target, then perform branch
// [RL10] Eight-bit ALU for arithmetic, logic, rotate
// [RL11] Data moves through accumulator and ALU
// [RL12] Control registers in data memory, direct/indirect
// [RL13] Counter advances by one unless branching
// [RL14] Taken skip discards prefetch, inserts dummy
// [RL15] Reset loads vector zero into counter
// [RL16] Low byte write: page jump plus dummy
// [RL17] Reset release restarts at first phase
module ffs_sequencer
	import ffs_pkg::*;
#(
	parameter int DMEM_DEPTH = 32
)
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Oscillator source selection
	input wire logic [1:0] srcSel,
	input wire logic [3:0] srcTick,
	// Program memory
	output logic [PC_W-1:0] pmAddr,
	output logic pmRead,
	input wire logic [WORD_W-1:0] pmData,
	// Status
	output logic [3:0] phaseClk,
	output logic instrCycle,
	output logic dummyCycle,
	output logic [PC_W-1:0] pcOut,
	output logic [DATA_W-1:0] accOut
);

	// ==========================================================
	// Functions
	localparam int AW = $clog2(DMEM_DEPTH);

	// Shared by immediate and extended operations
	function automatic logic [7:0] ffs_alu(input logic [3:0] op, input logic [7:0] a, input logic [7:0] b);
		case (op) // [RL10]
			ALU_ADD: return a + b;
			ALU_SUB: return a - b;
			ALU_AND: return a & b;
			ALU_OR: return a | b;
			ALU_XOR: return a ^ b;
			ALU_ROL: return {a[6:0], a[7]};
			ALU_ROR: return {a[0], a[7:1]};
			ALU_INC: return a + 8'h01;
			ALU_DEC: return a - 8'h01;
			default: return b; // Plain move
		endcase
	endfunction : ffs_alu

	// Indirect slot redirects through the pointer register
	function automatic logic [7:0] ffs_ea(input logic [7:0] a, input logic [7:0] ptr);
		return (a == MAP_INDIRECT) ? ptr : a; // [RL12]
	endfunction : ffs_ea

	// ==========================================================
	// State
	ffs_phase_e phase_r, phase_nxt; // Current phase
	logic [3:0] phaseClk_r, phaseClk_nxt; // One-hot phase outputs
	logic [PC_W-1:0] pc_r, pc_nxt; // Next fetch address
	logic [PC_W-1:0] pmAddr_r, pmAddr_nxt; // Address being fetched
	logic fetchEn_r, fetchEn_nxt; // Fetch active this cycle
	logic [WORD_W-1:0] fetch_r, fetch_nxt; // Prefetched word
	logic [WORD_W-1:0] exec_r, exec_nxt; // Executing word
	logic execValid_r, execValid_nxt; // Low in dummy cycles
	logic [PC_W-1:0] execPc_r, execPc_nxt; // Address of executing word
	logic ext_r, ext_nxt; // Second cycle of extended op
	logic [7:0] acc_r, acc_nxt; // Accumulator
	logic dummy_r, dummy_nxt; // Dummy cycle indicator
	logic instr_r, instr_nxt; // Instruction cycle start pulse
	logic [7:0] dmem_r [DMEM_DEPTH]; // Data memory incl. control registers
	logic [7:0] dmem_nxt [DMEM_DEPTH];
	logic [1:0] selMeta_r, selSync_r; // Source select synchroniser

	// ==========================================================
	// Decode, evaluated during T2..T4 from the stable executing word
	logic sysTick; // Selected system clock enable
	logic commit; // End of T4: execute and fetch
	logic [3:0] opc; // Opcode
	logic [7:0] ea; // Effective data address
	logic [7:0] rdVal; // Operand read from data memory
	logic isPcl; // Operand is the counter low byte

	// Switching sources mid-cycle only changes the length of the current phase
	assign sysTick = srcTick[selSync_r]; // [RL2]
	assign commit = sysTick && (phase_r == PH_T4); // [RL5]
	assign opc = exec_r[WORD_W-1:OPC_LO]; // [RL4]
	assign ea = ffs_ea(exec_r[7:0], dmem_r[MAP_POINTER[AW-1:0]]);
	assign isPcl = (ea == MAP_PCLOW);
	// Addresses beyond the depth alias onto the array
	assign rdVal = isPcl ? execPc_r[7:0] : dmem_r[ea[AW-1:0]]; // [RL12]

	// ==========================================================
	// Next-state logic
	always_comb
	begin
		logic [PC_W-1:0] newPc;
		logic hold;
		logic flush;
		newPc = pc_r;
		hold = 1'b0;
		flush = 1'b0;
		phase_nxt = phase_r;
		phaseClk_nxt = phaseClk_r;
		pc_nxt = pc_r;
		pmAddr_nxt = pmAddr_r;
		fetchEn_nxt = fetchEn_r;
		fetch_nxt = fetch_r;
		exec_nxt = exec_r;
		execValid_nxt = execValid_r;
		execPc_nxt = execPc_r;
		ext_nxt = ext_r;
		acc_nxt = acc_r;
		dummy_nxt = dummy_r;
		instr_nxt = commit;
		dmem_nxt = dmem_r;
		// Phase stepping on each system clock enable
		if (sysTick)
		begin
			unique case (phase_r) // [RL1]
				PH_T1: phase_nxt = PH_T2;
				PH_T2: phase_nxt = PH_T3;
				PH_T3: phase_nxt = PH_T4;
				PH_T4: phase_nxt = PH_T1;
			endcase
			unique case (phase_nxt) // [RL1]
				PH_T1: phaseClk_nxt = 4'h1;
				PH_T2: phaseClk_nxt = 4'h2;
				PH_T3: phaseClk_nxt = 4'h4;
				PH_T4: phaseClk_nxt = 4'h8;
			endcase
		end
		// Word is captured at the end of T1, one cycle ahead of its use
		if (sysTick && (phase_r == PH_T1) && fetchEn_r)
		begin
			fetch_nxt = pmData; // [RL6]
		end
		if (commit)
		begin
			if (execValid_r)
			begin
				unique case (opc)
					OPC_ALU:
					begin
						acc_nxt = ffs_alu(exec_r[11:ALUOP_LO], acc_r, exec_r[7:0]); // [RL11]
					end
					OPC_STORE:
					begin
						if (isPcl)
						begin
							// Jump within the current 256-word page
							newPc = {execPc_r[PC_W-1:8], acc_r}; // [RL16]
							flush = 1'b1; // [RL16]
						end
						else
						begin
							dmem_nxt[ea[AW-1:0]] = acc_r; // [RL11]
						end
					end
					OPC_LOAD:
					begin
						acc_nxt = rdVal; // [RL11]
					end
					OPC_JUMP, OPC_CALL:
					begin
						// Target taken now, branch performed by the next fetch
						newPc = {execPc_r[PC_W-1:TGT_W], exec_r[TGT_W-1:0]}; // [RL9]
						flush = 1'b1; // [RL8]
					end
					OPC_SKZ:
					begin
						flush = (rdVal == 8'h00); // [RL14]
					end
					OPC_SKNZ:
					begin
						flush = (rdVal != 8'h00); // [RL14]
					end
					OPC_EXT:
					begin
						if (!ext_r)
						begin
							hold = 1'b1; // [RL7]
							ext_nxt = 1'b1;
						end
						else
						begin
							ext_nxt = 1'b0;
							acc_nxt = ffs_alu(exec_r[11:ALUOP_LO], acc_r, rdVal); // [RL7]
						end
					end
					default:
					begin
						// Unused opcodes execute as no-operation
						acc_nxt = acc_r;
					end
				endcase
			end
			if (hold)
			begin
				// Prefetched word is kept, so no new fetch this cycle
				fetchEn_nxt = 1'b0;
				dummy_nxt = 1'b0;
			end
			else
			begin
				pmAddr_nxt = newPc; // [RL3]
				pc_nxt = newPc + 1'b1; // [RL13]
				fetchEn_nxt = 1'b1; // [RL3]
				exec_nxt = fetch_r; // [RL6]
				execPc_nxt = pmAddr_r;
				execValid_nxt = !flush; // [RL14]
				dummy_nxt = flush; // [RL8]
			end
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			phase_r <= PH_T1; // [RL17]
			phaseClk_r <= PHASE_T1_HOT; // [RL17]
			pc_r <= RESET_VECTOR + 14'h0001; // [RL15]
			pmAddr_r <= RESET_VECTOR; // [RL15]
			fetchEn_r <= 1'b1;
			fetch_r <= '0;
			exec_r <= '0;
			execValid_r <= 1'b0;
			execPc_r <= RESET_VECTOR;
			ext_r <= 1'b0;
			acc_r <= ACC_RESET;
			dummy_r <= 1'b0;
			instr_r <= 1'b0;
			for (int i = 0; i < DMEM_DEPTH; i++)
			begin
				dmem_r[i] <= 8'h00;
			end
		end
		else
		begin
			phase_r <= phase_nxt;
			phaseClk_r <= phaseClk_nxt;
			pc_r <= pc_nxt;
			pmAddr_r <= pmAddr_nxt;
			fetchEn_r <= fetchEn_nxt;
			fetch_r <= fetch_nxt;
			exec_r <= exec_nxt;
			execValid_r <= execValid_nxt;
			execPc_r <= execPc_nxt;
			ext_r <= ext_nxt;
			acc_r <= acc_nxt;
			dummy_r <= dummy_nxt;
			instr_r <= instr_nxt;
			dmem_r <= dmem_nxt;
		end
	end

	// ==========================================================
	// Source select synchroniser, the select is a pin
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			selMeta_r <= SRC_FAST_XTAL;
			selSync_r <= SRC_FAST_XTAL;
		end
		else
		begin
			selMeta_r <= srcSel;
			selSync_r <= selMeta_r;
		end
	end

	// ==========================================================
	// Outputs
	assign pmAddr = pmAddr_r;
	assign pmRead = fetchEn_r && (phase_r == PH_T1); // [RL3]
	assign phaseClk = phaseClk_r;
	assign instrCycle = instr_r;
	assign dummyCycle = dummy_r;
	assign pcOut = pc_r;
	assign accOut = acc_r;

	// ==========================================================
	// Assertions
	logic firstFetch_r; // High until the first cycle completes
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			firstFetch_r <= 1'b1;
		else if (commit)
			firstFetch_r <= 1'b0;
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	phase_onehot_a: assert property ($onehot(phaseClk_r)) else $error("phase clocks not one-hot"); // [RL1]
	cycle_wrap_a: assert property (commit |=> phaseClk_r == 4'h1 && instrCycle) else $error("T4 did not wrap"); // [RL5]
	fetch_t1_a: assert property (pmRead |-> phaseClk_r[0] && pcOut == pmAddr + 14'h0001) else $error("bad fetch"); // [RL3]
	seq_step_a: assert property (commit && execValid_r && opc == OPC_ALU
		|=> pmAddr == $past(pmAddr) + 14'h0001 && !dummyCycle) else $error("counter did not step"); // [RL13]
	branch_two_a: assert property (commit && execValid_r && (opc == OPC_JUMP || opc == OPC_CALL)
		|=> dummyCycle && !execValid_r
		&& pmAddr == {$past(execPc_r[13:12]), $past(exec_r[11:0])}) else $error("branch wrong"); // [RL8]
	skip_flush_a: assert property (commit && execValid_r && opc == OPC_SKZ && rdVal == 8'h00
		|=> dummyCycle && !execValid_r) else $error("skip not flushed"); // [RL14]
	pcl_jump_a: assert property (commit && execValid_r && opc == OPC_STORE && isPcl
		|=> dummyCycle && pmAddr == {$past(execPc_r[13:8]), $past(acc_r)}) else $error("page jump wrong"); // [RL16]
	ext_hold_a: assert property (commit && execValid_r && opc == OPC_EXT && !ext_r
		|=> !pmRead && $stable(exec_r) && $stable(pmAddr)) else $error("extended not held"); // [RL7]
	reset_vec_a: assert property (firstFetch_r |-> pmAddr == RESET_VECTOR) else $error("not at vector"); // [RL15]

	branch_c: cover property (commit && execValid_r && opc == OPC_JUMP);
	skip_c: cover property (commit && execValid_r && opc == OPC_SKNZ && rdVal != 8'h00);
	pcl_c: cover property (commit && execValid_r && opc == OPC_STORE && isPcl);
	ext_c: cover property (commit && ext_r);

endmodule : ffs_sequencer

// ### src/ffs_pkg.sv
// Shared constants and types for the four-phase fetch/execute sequencer
package ffs_pkg;

	// ==========================================================
	// Widths
	localparam int PC_W = 14; // Program counter width (16K words)
	localparam int WORD_W = 16; // Program memory word width
	localparam int DATA_W = 8; // Accumulator and ALU width

	// ==========================================================
	// Phase clocks, Gray coded along T1-T2-T3-T4
	typedef enum logic [1:0]
	{
		PH_T1 = 2'h0,
		PH_T2 = 2'h1,
		PH_T3 = 2'h3,
		PH_T4 = 2'h2
	} ffs_phase_e;
	localparam logic [3:0] PHASE_T1_HOT = 4'h1; // One-hot code of T1

	// ==========================================================
	// Oscillator source select codes
	localparam logic [1:0] SRC_FAST_XTAL = 2'h0; // external_fast_crystal_source
	localparam logic [1:0] SRC_SLOW_XTAL = 2'h1; // external_slow_crystal_source
	localparam logic [1:0] SRC_FAST_RC = 2'h2; // internal_fast_rc_source
	localparam logic [1:0] SRC_SLOW_RC = 2'h3; // internal_slow_rc_source

	// ==========================================================
	// Instruction word fields
	localparam int OPC_LO = 12; // Opcode in [15:12]
	localparam int ALUOP_LO = 8; // ALU operation in [11:8]
	localparam int TGT_W = 12; // Branch target in [11:0]
	localparam logic [3:0] OPC_ALU = 4'h0; // acc = alu(acc, imm)
	localparam logic [3:0] OPC_STORE = 4'h1; // mem = acc
	localparam logic [3:0] OPC_LOAD = 4'h2; // acc = mem
	localparam logic [3:0] OPC_JUMP = 4'h3; // Jump
	localparam logic [3:0] OPC_CALL = 4'h4; // Call (no stack here)
	localparam logic [3:0] OPC_SKZ = 4'h5; // Skip if mem zero
	localparam logic [3:0] OPC_SKNZ = 4'h6; // Skip if mem nonzero
	localparam logic [3:0] OPC_EXT = 4'h7; // Extended: acc = alu(acc, mem)

	// ==========================================================
	// ALU operations
	localparam logic [3:0] ALU_ADD = 4'h0;
	localparam logic [3:0] ALU_SUB = 4'h1;
	localparam logic [3:0] ALU_AND = 4'h2;
	localparam logic [3:0] ALU_OR = 4'h3;
	localparam logic [3:0] ALU_XOR = 4'h4;
	localparam logic [3:0] ALU_ROL = 4'h5;
	localparam logic [3:0] ALU_ROR = 4'h6;
	localparam logic [3:0] ALU_INC = 4'h7;
	localparam logic [3:0] ALU_DEC = 4'h8;

	// ==========================================================
	// Data memory map of control registers, reset values
	localparam logic [7:0] MAP_INDIRECT = 8'h00; // Access through pointer
	localparam logic [7:0] MAP_POINTER = 8'h01; // Indirect pointer
	localparam logic [7:0] MAP_PCLOW = 8'h02; // program_counter_low_byte
	localparam logic [PC_W-1:0] RESET_VECTOR = 14'h0000;
	localparam logic [7:0] ACC_RESET = 8'h00;

endpackage : ffs_pkg

// ### verif/ffs_pmem_model.sv
// Program memory model feeding the sequencer's fetch port
`timescale 1ns/100ps

module ffs_pmem_model
	import ffs_pkg::*;
(
	// Clock
	input wire logic core_clk,
	// Fetch port
	input wire logic [PC_W-1:0] pmAddr,
	input wire logic pmRead,
	output logic [WORD_W-1:0] pmData
);
	// ==========================================================
	// Storage, filled by the bench; no-op words by default
	logic [WORD_W-1:0] mem [0:(1<<PC_W)-1];
	logic [WORD_W-1:0] lastWord = '0; // Last word handed out

	initial
	begin
		foreach (mem[i]) mem[i] = 16'hF000;
	end

	// Word tracks the address while read; otherwise the bus shows the
	// inverse of the last word so a stale sample cannot pass for good
	always_comb pmData = pmRead ? mem[pmAddr] : ~lastWord;

	// Remember what was last driven
	always @(posedge core_clk)
		if (pmRead) lastWord <= mem[pmAddr];
endmodule : ffs_pmem_model

// ### verif/tb.sv
// Self-checking bench for the four-phase fetch/execute sequencer
`timescale 1ns/100ps

module tb;
	import ffs_pkg::*;
	// ==========================================================
	// Stimulus and observed signals
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [1:0] srcSel = 2'h0; // Oscillator source select
	logic [3:0] srcTick = 4'h0; // Per-source clock enables
	logic [PC_W-1:0] pmAddr, pcOut;
	logic pmRead, instrCycle, dummyCycle;
	logic [WORD_W-1:0] pmData;
	logic [3:0] phaseClk;
	logic [DATA_W-1:0] accOut;
	int failCount = 0;
	int nCompared = 0;
	int cyc = 0; // Watchdog count
	int icCount = 0; // Instruction cycles since release
	logic [31:0] trace [$]; // {cycle index, dummy, address} per fetch

	ffs_sequencer dut (.core_clk(core_clk), .rst_n(rst_n), .srcSel(srcSel), .srcTick(srcTick),
		.pmAddr(pmAddr), .pmRead(pmRead), .pmData(pmData), .phaseClk(phaseClk),
		.instrCycle(instrCycle), .dummyCycle(dummyCycle), .pcOut(pcOut), .accOut(accOut));
	ffs_pmem_model pm (.core_clk(core_clk), .pmAddr(pmAddr), .pmRead(pmRead), .pmData(pmData));

	// ==========================================================
	// Clock, 5 ns period
	initial
	begin
		forever #2.5 core_clk = ~core_clk;
	end

	// Fetch monitor: a fetch lands on a selected tick during a read
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			failCount++;
			close_out();
		end
		if (!rst_n)
		begin
			icCount = 0;
			trace.delete();
		end
		else
		begin
			// A pulse here opens the cycle whose fetch ends now
			if (pmRead && srcTick[srcSel])
				trace.push_back({8'h00, 8'(icCount + instrCycle), 1'b0, dummyCycle, pmAddr});
			if (instrCycle) icCount++;
		end
	end

	// ==========================================================
	// Shared helpers
	task automatic check(string what, logic [31:0] exp, logic [31:0] got);
		nCompared++;
		if (got !== exp)
		begin
			$display("BAD %s expected %h seen %h", what, exp, got);
			failCount++;
		end
	endtask : check

	// Reset for 13 cycles and look at the held outputs meanwhile
	task automatic do_reset();
		@(posedge core_clk);
		rst_n <= 1'b0;
		repeat (12) @(posedge core_clk);
		#1;
		check("rst phase", 32'h1, 32'(phaseClk));
		check("rst addr", 32'(RESET_VECTOR), 32'(pmAddr));
		check("rst pc", 32'h1, 32'(pcOut));
		check("rst read", 32'h1, 32'(pmRead));
		check("rst acc", 32'(ACC_RESET), 32'(accOut));
		@(posedge core_clk);
		rst_n <= 1'b1;
	endtask : do_reset

	// ==========================================================
	// Only the selected source advances the phases, one per tick
	task automatic t_sources();
		for (int s = 0; s < 4; s++)
		begin
			do_reset();
			srcSel <= 2'(s);
			repeat (3) @(posedge core_clk);
			srcTick <= 4'hF & ~(4'h1 << s);
			repeat (8) @(posedge core_clk);
			#1;
			check("foreign ticks", 32'h1, 32'(phaseClk));
			@(posedge core_clk);
			srcTick <= 4'h1 << s;
			for (int k = 1; k <= 4; k++)
			begin
				@(posedge core_clk);
				#1;
				check("phase", 32'(4'h1 << (k % 4)), 32'(phaseClk));
			end
			check("cycle pulse", 32'h1, 32'(instrCycle));
			srcTick <= 4'h0;
		end
		srcSel <= 2'h0;
		repeat (3) @(posedge core_clk);
	endtask : t_sources

	// Each ALU operation on a moved-in operand and an immediate
	task automatic t_alu();
		logic [7:0] expAcc [9] = '{8'h69, 8'h4B, 8'h0A, 8'h5F, 8'h55, 8'hB4, 8'h2D, 8'h5B, 8'h59};
		for (int op = 0; op < 9; op++)
		begin
			pm.mem[0] = 16'h0F5A;
			pm.mem[1] = {OPC_ALU, 4'(op), 8'h0F};
			pm.mem[2] = 16'h3002;
			do_reset();
			srcTick <= 4'hF;
			repeat (60) @(posedge core_clk);
			#1;
			check("alu result", 32'(expAcc[op]), 32'(accOut));
			srcTick <= 4'h0;
		end
	endtask : t_alu

	// Extended op, taken skip, call and low-byte write in one program
	task automatic t_flow();
		logic [15:0] prog [0:7] = '{16'h0005, 16'h0700, 16'h1004, 16'h7004,
			16'h6004, 16'h0001, 16'h4010, 16'h0001};
		logic [13:0] expAddr [12] = '{0, 1, 2, 3, 4, 5, 6, 7, 14'h10, 14'h11, 14'h12, 14'h0A};
		logic [7:0] expIc [12] = '{0, 1, 2, 3, 4, 6, 7, 8, 9, 10, 11, 12};
		logic expDummy [12] = '{0, 0, 0, 0, 0, 0, 1, 0, 1, 0, 0, 1};
		foreach (prog[i]) pm.mem[i] = prog[i];
		pm.mem[16'h10] = 16'h0102;
		pm.mem[16'h11] = 16'h1002;
		pm.mem[16'h12] = 16'h0001;
		pm.mem[16'h0A] = 16'h300A;
		do_reset();
		srcTick <= 4'hF;
		repeat (80) @(posedge core_clk);
		#1;
		check("final acc", 32'h0A, 32'(accOut));
		check("fetch count", 1, 32'(trace.size() >= 12));
		for (int i = 0; i < 12 && i < trace.size(); i++)
		begin
			check("fetch addr", 32'(expAddr[i]), 32'(trace[i][13:0]));
			check("fetch cycle", 32'(expIc[i]), 32'(trace[i][23:16]));
			check("fetch dummy", 32'(expDummy[i]), 32'(trace[i][14]));
		end
		srcTick <= 4'h0;
	endtask : t_flow

	// Loads, skips taken and not taken, indirect store and extended read through the pointer;
	// every wrong turn except at the nonzero skip, whose result the counter load overwrites, leaves a different accumulator value behind
	task automatic t_data();
		logic [15:0] prog [13] = '{16'h0003, 16'h1001, 16'h1000, 16'h0F00, 16'h6003, 16'h0040, 16'h2002,
			16'h5000, 16'h0010, 16'h5005, 16'h0080, 16'h7000, 16'h300C};
		foreach (prog[i]) pm.mem[i] = prog[i];
		do_reset();
		srcTick <= 4'hF;
		repeat (120) @(posedge core_clk);
		#1;
		check("data acc", 32'h19, 32'(accOut));
		check("skip nz dummy", 32'h1, 32'(trace[6][14]));
		check("skip z dummy", 32'h1, 32'(trace[11][14]));
		check("skip z addr", 32'h0B, 32'(trace[11][13:0]));
		srcTick <= 4'h0;
	endtask : t_data

	// ==========================================================
	// Verdict, reached from the main sequence or the watchdog
	task automatic close_out();
		$display("Compared %0d, mismatches %0d", nCompared, failCount);
		if (failCount == 0 && nCompared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : close_out

	// Main sequence
	initial
	begin
		t_sources();
		t_alu();
		t_flow();
		t_data();
		close_out();
	end
endmodule : tb
